/* File: bench/i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model
  import charger_cfg_pkg::*;
#(
  parameter logic [6:0] ADDR = SLAVE_ADDR,
  parameter int         HALF = 8
) (
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_pull
);
  int nak_cnt = 0;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic gap();
    repeat (HALF) @(negedge clk);
  endtask

  // Start and repeated start alike
  task automatic start();
    repeat (2) @(negedge clk);
    sda_pull = 1'b0;
    gap();
    scl = 1'b1;
    gap();
    sda_pull = 1'b1;
    gap();
    scl = 1'b0;
  endtask

  task automatic stop();
    repeat (2) @(negedge clk);
    sda_pull = 1'b1;
    gap();
    scl = 1'b1;
    gap();
    sda_pull = 1'b0;
    gap();
  endtask

  // Data moves two cycles after SCL falls, never beside an SCL edge
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(negedge clk);
    sda_pull = !b;
    gap();
    scl = 1'b1;
    gap();
    r = sda_in;
    scl = 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic mack, input logic chk,
                         output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(mack, a);
    if (chk && a !== 1'b0) begin
      nak_cnt++;
    end
  endtask

  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    logic [7:0] q;
    if (off == ADDR_OVP_TEST) begin
      d[1:0] = 2'b00;
    end
    start();
    byte_io({ADDR, 1'b0}, 1'b1, 1'b1, q);
    byte_io(off, 1'b1, 1'b1, q);
    byte_io(d, 1'b1, 1'b1, q);
    stop();
  endtask

  task automatic rd(input logic [7:0] off, output logic [7:0] d);
    logic [7:0] q;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, 1'b1, q);
    byte_io(off, 1'b1, 1'b1, q);
    start();
    byte_io({ADDR, 1'b1}, 1'b1, 1'b1, q);
    // Single byte, closed by a not-acknowledge
    byte_io(8'hFF, 1'b1, 1'b0, d);
    stop();
  endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import charger_cfg_pkg::*;
;
  localparam int         LIMIT_CYC = 90000;
  localparam logic [5:0] TIN [6]   = '{6'h20, 6'h18, 6'h08, 6'h04, 6'h06, 6'h07};
  localparam logic [2:0] TCODE [6] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
  localparam logic [2:0] TCODE_X [6] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       scl;
  logic       pull;
  logic       sda_oe;
  logic       sda_w;
  logic       sda_o;
  logic       fast = 1'b0;
  logic [2:0] loops = 3'h0;
  logic       inp = 1'b1;
  logic [5:0] therm = 6'h00;
  logic       dpdm = 1'b0;
  logic       term = 1'b0;
  logic       batt = 1'b0;
  logic       fault;
  logic       half;
  logic       batoff;
  logic [3:0] tstat;
  logic [3:0] tstat_x;
  logic [2:0] ovsel;
  logic       dpon;
  logic       bdrun;
  logic       bfound;
  logic       production_test_mode;
  logic       ilim;
  int         failures = 0;
  int         checks_done = 0;
  int         cycles = 0;

  always #5 clk = ~clk;
  // Open-drain wire with pull-up
  assign sda_w = !pull && (!sda_oe || sda_o);

  charger_safety_config_regs #(
    .TICK_CYCLES(4)
  ) charger_safety_config_regs_i (
    .CLK_SYS           (clk),
    .RST               (rst),
    .SCL_IN            (scl),
    .SDA_IN            (sda_w),
    .SDA_OUT           (sda_o),
    .SDA_OE            (sda_oe),
    .THERMAL_REG_ACTIVE(loops[0]),
    .INPUT_VMGMT_ACTIVE(loops[1]),
    .PATH_MGMT_ACTIVE  (loops[2]),
    .FAST_CHARGE_ACTIVE(fast),
    .INPUT_PRESENT     (inp),
    .THERM_OPEN        (therm[5]),
    .THERM_ABOVE_HOT   (therm[4]),
    .THERM_ABOVE_WARM  (therm[3]),
    .THERM_BELOW_COOL  (therm[2]),
    .THERM_BELOW_COLD  (therm[1]),
    .THERM_BELOW_FREEZE(therm[0]),
    .DPDM_DONE         (dpdm),
    .TERM_DONE         (term),
    .BATTERY_PRESENT   (batt),
    .SAFETY_TIMER_FAULT(fault),
    .TIMER_HALF_SPEED  (half),
    .BATFET_OFF        (batoff),
    .CHARGE_SUSPEND    (tstat[3]),
    .VREG_REDUCED      (tstat[2]),
    .ICHG_REDUCED      (tstat[1]),
    .COLD_CHARGE_LIMIT (tstat[0]),
    .OVERVOLT_SEL      (ovsel),
    .DPLUS_SOURCE_ON   (dpon),
    .BATDET_RUN        (bdrun),
    .BATTERY_FOUND     (bfound),
    .PROD_TEST_ACTIVE  (production_test_mode),
    .ILIM_DISABLE      (ilim)
  );

  i2c_host_model i2c_host_model_i (
    .clk     (clk),
    .sda_in  (sda_w),
    .scl     (scl),
    .sda_pull(pull)
  );

  // Extended-cold variant, bus idle; only its zone outputs are watched
  charger_safety_config_regs #(
    .TICK_CYCLES (4),
    .EXT_COLD_OPT(1'b1)
  ) charger_safety_config_regs_ext_i (
    .CLK_SYS           (clk),
    .RST               (rst),
    .SCL_IN            (1'b1),
    .SDA_IN            (1'b1),
    .SDA_OUT           (),
    .SDA_OE            (),
    .THERMAL_REG_ACTIVE(loops[0]),
    .INPUT_VMGMT_ACTIVE(loops[1]),
    .PATH_MGMT_ACTIVE  (loops[2]),
    .FAST_CHARGE_ACTIVE(fast),
    .INPUT_PRESENT     (inp),
    .THERM_OPEN        (therm[5]),
    .THERM_ABOVE_HOT   (therm[4]),
    .THERM_ABOVE_WARM  (therm[3]),
    .THERM_BELOW_COOL  (therm[2]),
    .THERM_BELOW_COLD  (therm[1]),
    .THERM_BELOW_FREEZE(therm[0]),
    .DPDM_DONE         (dpdm),
    .TERM_DONE         (term),
    .BATTERY_PRESENT   (batt),
    .SAFETY_TIMER_FAULT(),
    .TIMER_HALF_SPEED  (),
    .BATFET_OFF        (),
    .CHARGE_SUSPEND    (tstat_x[3]),
    .VREG_REDUCED      (tstat_x[2]),
    .ICHG_REDUCED      (tstat_x[1]),
    .COLD_CHARGE_LIMIT (tstat_x[0]),
    .OVERVOLT_SEL      (),
    .DPLUS_SOURCE_ON   (),
    .BATDET_RUN        (),
    .BATTERY_FOUND     (),
    .PROD_TEST_ACTIVE  (),
    .ILIM_DISABLE      ()
  );

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Expected zone outputs: suspend, reduced voltage, reduced current, cold limit
  function automatic logic [3:0] zone_act(input logic [2:0] c);
    return {c inside {THERM_HOT, THERM_COLD, THERM_FREEZE}, c == THERM_WARM,
            c == THERM_COOL, c == THERM_CHILL};
  endfunction

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    i2c_host_model_i.rd(a, q);
    cmp(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i2c_host_model_i.wr(a, d);
  endtask

  task automatic pause(input int n = 6);
    repeat (n) @(negedge clk);
  endtask

  task automatic end_sim();
    $display("checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT_CYC) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    pause(10);
    rst = 1'b0;
    pause(4);
    cmp(8'(ovsel), 8'h07);
    rchk(ADDR_TIMER_THERM, 8'hA8);
    rchk(ADDR_OVP_TEST, 8'hE0);
    rchk(8'h07, 8'h00);
    $display("test reset_values done");
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_OVP_TEST, {k[2:0], 5'h00});
      cmp(8'(ovsel), 8'(k[2:0]));
    end
    rchk(ADDR_OVP_TEST, 8'hE0);
    $display("test overvoltage done");
    for (int k = 0; k < 6; k++) begin
      therm = TIN[k];
      pause();
      rchk(ADDR_TIMER_THERM, {5'h15, TCODE[k]});
      if (k > 0) begin
        cmp(8'(tstat), 8'(zone_act(TCODE[k])));
        cmp(8'(tstat_x), 8'(zone_act(TCODE_X[k])));
      end
      if (TCODE[k] == THERM_COLD) begin
        cmp(8'(tstat[3]), 8'h01);
      end
    end
    therm = 6'h00;
    wr(ADDR_TIMER_THERM, 8'hAF);
    rchk(ADDR_TIMER_THERM, 8'hA8);
    therm = 6'h18;
    wr(ADDR_TIMER_THERM, 8'hA0);
    rchk(ADDR_TIMER_THERM, 8'hA7);
    wr(ADDR_TIMER_THERM, 8'hA8);
    rchk(ADDR_TIMER_THERM, 8'hA9);
    therm = 6'h00;
    $display("test thermistor done");
    fast = 1'b1;
    for (int k = 0; k < 3; k++) begin
      loops = 3'h1 << k;
      pause();
      cmp(8'(half), 8'h01);
    end
    wr(ADDR_TIMER_THERM, 8'h28);
    cmp(8'(half), 8'h00);
    wr(ADDR_TIMER_THERM, 8'hA8);
    cmp(8'(half), 8'h01);
    loops = 3'h0;
    pause();
    cmp(8'(half), 8'h00);
    $display("test slowdown done");
    fast = 1'b0;
    wr(ADDR_TIMER_THERM, 8'h88);
    fast = 1'b1;
    pause(10000);
    cmp(8'(fault), 8'h00);
    for (int n = 0; n < 1200 && fault !== 1'b1; n++) begin
      @(negedge clk);
    end
    cmp(8'(fault), 8'h01);
    wr(ADDR_TIMER_THERM, 8'hE8);
    cmp(8'(fault), 8'h00);
    fast = 1'b0;
    pause();
    fast = 1'b1;
    pause(12000);
    cmp(8'(fault), 8'h00);
    fast = 1'b0;
    wr(ADDR_TIMER_THERM, 8'h88);
    loops = 3'h1;
    fast = 1'b1;
    pause(12000);
    cmp(8'(fault), 8'h00);
    for (int n = 0; n < 10500 && fault !== 1'b1; n++) begin
      @(negedge clk);
    end
    cmp(8'(fault), 8'h01);
    fast = 1'b0;
    loops = 3'h0;
    $display("test safety_timer done");
    wr(ADDR_TIMER_THERM, 8'hB8);
    inp = 1'b0;
    pause();
    cmp(8'(batoff), 8'h01);
    inp = 1'b1;
    pause();
    cmp(8'(batoff), 8'h00);
    wr(ADDR_TIMER_THERM, 8'hA8);
    inp = 1'b0;
    pause();
    cmp(8'(batoff), 8'h00);
    inp = 1'b1;
    $display("test disconnect done");
    dpdm = 1'b1;
    pause();
    cmp(8'(dpon), 8'h01);
    wr(ADDR_OVP_TEST, 8'hF0);
    cmp(8'(dpon), 8'h00);
    wr(ADDR_OVP_TEST, 8'hE0);
    cmp(8'(dpon), 8'h01);
    $display("test dplus done");
    batt = 1'b1;
    pause();
    cmp(8'(bdrun), 8'h00);
    term = 1'b1;
    pause();
    cmp({6'h00, bdrun, bfound}, 8'h03);
    term = 1'b0;
    wr(ADDR_OVP_TEST, 8'hE8);
    cmp(8'(bdrun), 8'h01);
    wr(ADDR_OVP_TEST, 8'hE4);
    rchk(ADDR_OVP_TEST, 8'hE0);
    cmp({6'h00, production_test_mode, ilim}, 8'h00);
    batt = 1'b0;
    pause();
    wr(ADDR_OVP_TEST, 8'hE4);
    rchk(ADDR_OVP_TEST, 8'hE4);
    cmp({5'h00, production_test_mode, ilim, bdrun}, 8'h07);
    wr(ADDR_OVP_TEST, 8'hE0);
    cmp(8'(bdrun), 8'h00);
    $display("test detect_and_test_mode done");
    cmp(8'(i2c_host_model_i.nak_cnt), 8'h00);
    end_sim();
  end
endmodule

/* File: rtl/charger_cfg_pkg.sv */
package charger_cfg_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_TIMER_THERM = 8'h05;
  localparam logic [7:0] ADDR_OVP_TEST    = 8'h06;

  // Field positions, timer/thermistor register
  localparam int BIT_SLOWDOWN   = 7;
  localparam int BIT_LIMIT_HI   = 6;
  localparam int BIT_LIMIT_LO   = 5;
  localparam int BIT_DISCONNECT = 4;
  localparam int BIT_THERM_EN   = 3;
  // Field positions, overvoltage/test register
  localparam int BIT_OVP_HI     = 7;
  localparam int BIT_OVP_LO     = 5;
  localparam int BIT_DPLUS_REL  = 4;
  localparam int BIT_BATDET     = 3;
  localparam int BIT_PROD_TEST  = 2;

  // Reset values; timer register holds bits 7:3 only
  localparam logic [4:0] RST_TIMER_THERM = 5'h15;
  localparam logic [7:0] RST_OVP_TEST    = 8'hE0;

  // Safety limit codes
  localparam logic [1:0] LIMIT_OFF = 2'h3;

  // Thermistor fault codes
  localparam logic [2:0] THERM_NORMAL = 3'h0;
  localparam logic [2:0] THERM_HOT    = 3'h1;
  localparam logic [2:0] THERM_WARM   = 3'h2;
  localparam logic [2:0] THERM_COOL   = 3'h3;
  localparam logic [2:0] THERM_COLD   = 3'h4;
  localparam logic [2:0] THERM_CHILL  = 3'h5;
  localparam logic [2:0] THERM_FREEZE = 3'h6;
  localparam logic [2:0] THERM_OFF    = 3'h7;

  // Timing
  localparam int CLK_HZ      = 100_000_000;
  localparam int TICK_MS     = 1000;
  localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  // Fast-charge limits in hundredths of an hour
  localparam int LIMIT_SHORT_CH = 75;
  localparam int LIMIT_MID_CH   = 600;
  localparam int LIMIT_LONG_CH  = 900;
  localparam int SEC_PER_CH     = 36;

  // Serial slave; address value is arbitrary
  localparam logic [6:0] SLAVE_ADDR = 7'h2A;

  typedef enum logic [2:0] {
    SER_IDLE, SER_ADDR, SER_ACK_ADDR, SER_WBYTE, SER_ACK_W, SER_RBYTE, SER_ACK_R
  } ser_state_e;
endpackage

/* File: rtl/charger_safety_config_regs.sv */
`timescale 1ns/1ps
module charger_safety_config_regs
  import charger_cfg_pkg::*;
#(
  parameter int         TICK_CYCLES   = TICK_CYC,
  parameter logic       EXT_COLD_OPT  = 1'b0,
  parameter logic [6:0] DEV_ADDR      = SLAVE_ADDR
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       THERMAL_REG_ACTIVE,
  input  wire logic       INPUT_VMGMT_ACTIVE,
  input  wire logic       PATH_MGMT_ACTIVE,
  input  wire logic       FAST_CHARGE_ACTIVE,
  input  wire logic       INPUT_PRESENT,
  input  wire logic       THERM_OPEN,
  input  wire logic       THERM_ABOVE_HOT,
  input  wire logic       THERM_ABOVE_WARM,
  input  wire logic       THERM_BELOW_COOL,
  input  wire logic       THERM_BELOW_COLD,
  input  wire logic       THERM_BELOW_FREEZE,
  input  wire logic       DPDM_DONE,
  input  wire logic       TERM_DONE,
  input  wire logic       BATTERY_PRESENT,
  output logic            SAFETY_TIMER_FAULT,
  output logic            TIMER_HALF_SPEED,
  output logic            BATFET_OFF,
  output logic            CHARGE_SUSPEND,
  output logic            VREG_REDUCED,
  output logic            ICHG_REDUCED,
  output logic            COLD_CHARGE_LIMIT,
  output logic [2:0]      OVERVOLT_SEL,
  output logic            DPLUS_SOURCE_ON,
  output logic            BATDET_RUN,
  output logic            BATTERY_FOUND,
  output logic            PROD_TEST_ACTIVE,
  output logic            ILIM_DISABLE
);
  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam int NS = 14;

  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  logic          s_therm_reg;
  logic          s_vmgmt;
  logic          s_path;
  logic          s_fast;
  logic          s_input;
  logic          s_open;
  logic          s_hot;
  logic          s_warm;
  logic          s_cool;
  logic          s_cold;
  logic          s_freeze;
  logic          s_dpdm;
  logic          s_term;
  logic          s_bat;

  logic [7:3]    tt_r;
  logic [7:0]    ov_r;
  logic [2:0]    code_r;
  logic [2:0]    code_nxt;
  logic [7:0]    ptr;
  logic          wr_en;
  logic [7:0]    wr_data;
  logic [7:0]    rd_data;
  logic          sda_oe_i;

  logic [PW-1:0] pre_r;
  logic          tick;
  logic          half_r;
  logic [15:0]   sec_r;
  logic [15:0]   limit_s;
  logic          slow_c;

  // External levels cross into the clock domain here
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {THERMAL_REG_ACTIVE, INPUT_VMGMT_ACTIVE, PATH_MGMT_ACTIVE,
                  FAST_CHARGE_ACTIVE, INPUT_PRESENT, THERM_OPEN, THERM_ABOVE_HOT,
                  THERM_ABOVE_WARM, THERM_BELOW_COOL, THERM_BELOW_COLD,
                  THERM_BELOW_FREEZE, DPDM_DONE, TERM_DONE, BATTERY_PRESENT};
      sync2_r <= sync1_r;
    end
  end

  assign {s_therm_reg, s_vmgmt, s_path, s_fast, s_input, s_open, s_hot,
          s_warm, s_cool, s_cold, s_freeze, s_dpdm, s_term, s_bat} = sync2_r;

  i2c_reg_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slave (
    .clk     (CLK_SYS),
    .rst     (RST),
    .scl_in  (SCL_IN),
    .sda_in  (SDA_IN),
    .sda_oe  (sda_oe_i),
    .ptr     (ptr),
    .wr_en   (wr_en),
    .wr_data (wr_data),
    .rd_data (rd_data)
  );

  // Open drain: the pin only ever pulls low
  always_ff @(posedge CLK_SYS) begin
    SDA_OUT <= 1'b0;
  end

  assign SDA_OE = sda_oe_i;

  // Unmapped offsets read zero
  always_comb begin
    case (ptr)
      ADDR_TIMER_THERM: rd_data = {tt_r, code_r};
      ADDR_OVP_TEST:    rd_data = ov_r;
      default:          rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tt_r <= RST_TIMER_THERM;
    end else if (wr_en && ptr == ADDR_TIMER_THERM) begin
      tt_r <= wr_data[7:3];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ov_r <= RST_OVP_TEST;
    end else if (wr_en && ptr == ADDR_OVP_TEST) begin
      ov_r <= wr_data;
      if (wr_data[BIT_PROD_TEST] && !ov_r[BIT_PROD_TEST] && s_bat) begin
        ov_r[BIT_PROD_TEST] <= 1'b0;
      end
    end
  end

  // Cold faults rank above cool so a deeper zone always wins
  always_comb begin
    code_nxt = THERM_NORMAL;
    if (!tt_r[BIT_THERM_EN] || s_open) begin
      code_nxt = THERM_OFF;
    end else if (s_hot) begin
      code_nxt = THERM_HOT;
    end else if (s_warm) begin
      code_nxt = THERM_WARM;
    end else if (EXT_COLD_OPT && s_freeze) begin
      code_nxt = THERM_FREEZE;
    end else if (EXT_COLD_OPT && s_cold) begin
      code_nxt = THERM_CHILL;
    end else if (s_cold) begin
      code_nxt = THERM_COLD;
    end else if (s_cool) begin
      code_nxt = THERM_COOL;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      code_r <= THERM_NORMAL;
    end else begin
      code_r <= code_nxt;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      CHARGE_SUSPEND    <= 1'b0;
      VREG_REDUCED      <= 1'b0;
      ICHG_REDUCED      <= 1'b0;
      COLD_CHARGE_LIMIT <= 1'b0;
    end else begin
      CHARGE_SUSPEND    <= code_r == THERM_HOT || code_r == THERM_COLD ||
                           code_r == THERM_FREEZE;
      VREG_REDUCED      <= code_r == THERM_WARM;
      ICHG_REDUCED      <= code_r == THERM_COOL;
      COLD_CHARGE_LIMIT <= code_r == THERM_CHILL;
    end
  end

  // Prescaler gives one tick per second
  always_ff @(posedge CLK_SYS) begin
    if (RST || !s_fast || pre_r == PW'(TICK_CYCLES - 1)) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PW'(1);
    end
  end

  assign tick = s_fast && pre_r == PW'(TICK_CYCLES - 1);

  // slowdown only while a loop reduces current
  assign slow_c = tt_r[BIT_SLOWDOWN] && (s_therm_reg || s_vmgmt || s_path);

  always_comb begin
    case (tt_r[BIT_LIMIT_HI:BIT_LIMIT_LO])
      2'h0:    limit_s = 16'(LIMIT_SHORT_CH * SEC_PER_CH);
      2'h1:    limit_s = 16'(LIMIT_MID_CH * SEC_PER_CH);
      2'h2:    limit_s = 16'(LIMIT_LONG_CH * SEC_PER_CH);
      default: limit_s = 16'hFFFF;
    endcase
  end

  // Count restarts with each fast-charge phase
  always_ff @(posedge CLK_SYS) begin
    if (RST || !s_fast) begin
      sec_r  <= 16'h0000;
      half_r <= 1'b0;
    end else if (tick) begin
      half_r <= slow_c ? ~half_r : 1'b0;
      if ((!slow_c || half_r) && sec_r != 16'hFFFF) begin
        sec_r <= sec_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || !s_fast) begin
      SAFETY_TIMER_FAULT <= 1'b0;
    end else if (tt_r[BIT_LIMIT_HI:BIT_LIMIT_LO] == LIMIT_OFF) begin
      SAFETY_TIMER_FAULT <= 1'b0;
    end else if (sec_r >= limit_s) begin
      SAFETY_TIMER_FAULT <= 1'b1;
    end
  end

  // Output flops for the control bits
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      TIMER_HALF_SPEED <= 1'b0;
      BATFET_OFF       <= 1'b0;
      OVERVOLT_SEL     <= RST_OVP_TEST[BIT_OVP_HI:BIT_OVP_LO];
      DPLUS_SOURCE_ON  <= 1'b0;
      BATDET_RUN       <= 1'b0;
      BATTERY_FOUND    <= 1'b0;
      PROD_TEST_ACTIVE <= 1'b0;
      ILIM_DISABLE     <= 1'b0;
    end else begin
      TIMER_HALF_SPEED <= slow_c;
      BATFET_OFF       <= tt_r[BIT_DISCONNECT] && !s_input;
      OVERVOLT_SEL     <= ov_r[BIT_OVP_HI:BIT_OVP_LO];
      DPLUS_SOURCE_ON  <= s_dpdm && !ov_r[BIT_DPLUS_REL];
      BATDET_RUN       <= ov_r[BIT_BATDET] || s_term || ov_r[BIT_PROD_TEST];
      BATTERY_FOUND    <= BATDET_RUN && s_bat;
      PROD_TEST_ACTIVE <= ov_r[BIT_PROD_TEST];
      ILIM_DISABLE     <= ov_r[BIT_PROD_TEST];
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  chk_reset_timer_reg: assert property (
    $fell(RST) |-> tt_r == RST_TIMER_THERM && ov_r == RST_OVP_TEST)
    else $error("register reset value wrong");

  chk_half_speed_out: assert property (
    !tt_r[BIT_SLOWDOWN] |=> !TIMER_HALF_SPEED)
    else $error("timer slowed while slowdown is off");

  chk_limit_off_fault: assert property (
    tt_r[BIT_LIMIT_HI:BIT_LIMIT_LO] == LIMIT_OFF |=> !SAFETY_TIMER_FAULT)
    else $error("safety fault with timers disabled");

  chk_batfet_unplug: assert property (
    tt_r[BIT_DISCONNECT] && !s_input |=> BATFET_OFF)
    else $error("battery not isolated on unplug");

  chk_therm_disabled: assert property (
    !tt_r[BIT_THERM_EN] |=> code_r == THERM_OFF ##1 !CHARGE_SUSPEND)
    else $error("disabled thermistor not reported open");

  chk_hot_suspend: assert property (
    tt_r[BIT_THERM_EN] && !s_open && s_hot |=> code_r == THERM_HOT ##1 CHARGE_SUSPEND)
    else $error("hot zone did not suspend charging");

  chk_status_read: assert property (
    ptr == ADDR_TIMER_THERM |-> rd_data[2:0] == code_r)
    else $error("fault code read not live");

  chk_ovp_follow: assert property (
    wr_en && ptr == ADDR_OVP_TEST |=> ##1 OVERVOLT_SEL == $past(wr_data[7:5], 2))
    else $error("overvoltage level not applied");

  chk_dplus_release: assert property (
    ov_r[BIT_DPLUS_REL] |=> !DPLUS_SOURCE_ON)
    else $error("D+ source on after release");

  chk_batdet_force: assert property (
    ov_r[BIT_BATDET] |=> BATDET_RUN)
    else $error("forced detection not running");

  chk_test_refused: assert property (
    s_bat && !ov_r[BIT_PROD_TEST] |=> !ov_r[BIT_PROD_TEST])
    else $error("test mode entered with battery present");

  cov_timer_fault: cover property ($rose(SAFETY_TIMER_FAULT));
  cov_slowed_tick: cover property (tick && slow_c);
  cov_test_entry:  cover property ($rose(PROD_TEST_ACTIVE));
  cov_cold_zone:   cover property (code_r == THERM_COLD);
endmodule

/* File: rtl/i2c_reg_slave.sv */
`timescale 1ns/1ps
module i2c_reg_slave
  import charger_cfg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = SLAVE_ADDR
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe,
  output logic [7:0]      ptr,
  output logic            wr_en,
  output logic [7:0]      wr_data,
  input  wire logic [7:0] rd_data
);
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;
  ser_state_e st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic       rw_r;
  logic       have_ptr_r;
  logic       inc_r;
  logic       nack_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  assign scl_rise = scl_sync_r[1] & ~scl_d_r;
  assign scl_fall = ~scl_sync_r[1] & scl_d_r;
  assign start_c  = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
  assign stop_c   = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];

  always_ff @(posedge clk) begin
    wr_en <= 1'b0;
    if (rst || stop_c) begin
      st_r   <= SER_IDLE;
      sda_oe <= 1'b0;
      cnt_r  <= 4'h0;
      inc_r  <= 1'b0;
      if (rst) begin
        ptr     <= 8'h00;
        wr_data <= 8'h00;
        sh_r    <= 8'h00;
        tx_r    <= 8'h00;
        rw_r    <= 1'b0;
        nack_r  <= 1'b0;
        have_ptr_r <= 1'b0;
      end
    end else if (start_c) begin
      st_r   <= SER_ADDR;
      cnt_r  <= 4'h0;
      sda_oe <= 1'b0;
      have_ptr_r <= 1'b0;
    end else if (scl_rise) begin
      if (st_r == SER_ADDR || st_r == SER_WBYTE) begin
        sh_r  <= {sh_r[6:0], sda_sync_r[1]};
        cnt_r <= cnt_r + 4'h1;
      end else if (st_r == SER_RBYTE) begin
        cnt_r <= cnt_r + 4'h1;
      end else if (st_r == SER_ACK_R) begin
        nack_r <= sda_sync_r[1];
      end
    end else if (scl_fall) begin
      case (st_r)
        SER_ADDR: begin
          if (cnt_r == 4'h8) begin
            if (sh_r[7:1] == DEV_ADDR) begin
              st_r   <= SER_ACK_ADDR;
              sda_oe <= 1'b1;
              rw_r   <= sh_r[0];
            end else begin
              st_r <= SER_IDLE;
            end
          end
        end
        SER_ACK_ADDR, SER_ACK_R: begin
          cnt_r <= 4'h0;
          if (st_r == SER_ACK_R && nack_r) begin
            st_r   <= SER_IDLE;
            sda_oe <= 1'b0;
          end else if (st_r == SER_ACK_R || rw_r) begin
            st_r   <= SER_RBYTE;
            tx_r   <= rd_data;
            sda_oe <= ~rd_data[7];
          end else begin
            st_r   <= SER_WBYTE;
            sda_oe <= 1'b0;
          end
        end
        SER_WBYTE: begin
          if (cnt_r == 4'h8) begin
            st_r   <= SER_ACK_W;
            sda_oe <= 1'b1;
            if (!have_ptr_r) begin
              ptr        <= sh_r;
              have_ptr_r <= 1'b1;
            end else begin
              wr_en   <= 1'b1;
              wr_data <= sh_r;
              inc_r   <= 1'b1;
            end
          end
        end
        SER_ACK_W: begin
          st_r   <= SER_WBYTE;
          sda_oe <= 1'b0;
          cnt_r  <= 4'h0;
          inc_r  <= 1'b0;
          if (inc_r) begin
            ptr <= ptr + 8'h01;
          end
        end
        SER_RBYTE: begin
          if (cnt_r == 4'h8) begin
            st_r   <= SER_ACK_R;
            sda_oe <= 1'b0;
            ptr    <= ptr + 8'h01;
          end else begin
            sda_oe <= ~tx_r[6];
            tx_r   <= {tx_r[6:0], 1'b0};
          end
        end
        default: begin
          st_r   <= SER_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule
